/* sim/sse_top_tb.sv */
`timescale 1ns/10ps
module sse_top_tb;
	localparam int QTR = 4;
	localparam int UNIT = 4;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] prm_addr = 16'h0000;
	logic prm_wr = 1'b0;
	logic [15:0] prm_wdata = 16'h0000;
	logic prm_rd = 1'b0;
	logic [15:0] prm_rdata;
	logic pwm_tick = 1'b0;
	logic drive_run = 1'b0;
	logic [3:0] diagnostic_selector = 4'h0;
	logic quad_frequency_scale_flag = 1'b0;
	logic double_frequency_scale_flag = 1'b0;
	logic quad_magnitude_scale_flag = 1'b0;
	logic double_magnitude_scale_flag = 1'b0;
	logic signed [15:0] volt_alpha = 16'sh0000;
	logic signed [15:0] volt_beta = 16'sh0000;
	logic signed [15:0] curr_alpha = 16'sh0000;
	logic signed [15:0] curr_beta = 16'sh0000;
	logic [15:0] motor_current = 16'h0000;
	logic [15:0] rotor_angle;
	logic [15:0] filtered_freq;
	logic [7:0] park_current_cmd;
	logic parking_active, open_loop_active, closed_loop_active, start_fail, start_ok;
	logic [2:0] tick_cnt = 3'h0;
	logic rnd_en = 1'b0;
	logic rd_due = 1'b0;
	logic [31:0] seed = 32'h0000_82cf;
	logic [15:0] exp_q[$];
	string name_q[$];
	int n_mismatch = 0;
	int n_checks = 0;
	logic [15:0] addrs [17] = '{sse_pkg::A_CURR_GAIN, sse_pkg::A_VOLT_GAIN, sse_pkg::A_TORQUE,
		sse_pkg::A_SALIENCY, sse_pkg::A_RESIST, sse_pkg::A_MEAN_IND, sse_pkg::A_PROP,
		sse_pkg::A_INTEG, sse_pkg::A_SWITCH, sse_pkg::A_PARK_DUR, sse_pkg::A_PARK_CUR,
		sse_pkg::A_PARK_ANG1, sse_pkg::A_PARK_ANG2, sse_pkg::A_FLX_LOW, sse_pkg::A_FLX_HIGH,
		sse_pkg::A_FILT_BW, sse_pkg::A_CHK_DLY};
	logic [15:0] vals [17];

	sse_top #(.PARK_QTR_CYC(QTR), .CHK_UNIT_CYC(UNIT)) dut (.mclk(mclk), .reset(reset),
		.prm_addr(prm_addr), .prm_wr(prm_wr), .prm_wdata(prm_wdata), .prm_rd(prm_rd),
		.prm_rdata(prm_rdata), .pwm_tick(pwm_tick), .drive_run(drive_run),
		.diagnostic_selector(diagnostic_selector),
		.quad_frequency_scale_flag(quad_frequency_scale_flag),
		.double_frequency_scale_flag(double_frequency_scale_flag),
		.quad_magnitude_scale_flag(quad_magnitude_scale_flag),
		.double_magnitude_scale_flag(double_magnitude_scale_flag),
		.volt_alpha(volt_alpha), .volt_beta(volt_beta), .curr_alpha(curr_alpha),
		.curr_beta(curr_beta), .motor_current(motor_current), .rotor_angle(rotor_angle),
		.filtered_freq(filtered_freq), .park_current_cmd(park_current_cmd),
		.parking_active(parking_active), .open_loop_active(open_loop_active),
		.closed_loop_active(closed_loop_active), .start_fail(start_fail), .start_ok(start_ok));

	function automatic logic [15:0] xs_next();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	// Short PWM period keeps the open-loop ramps brief
	always @(posedge mclk) begin
		tick_cnt <= tick_cnt + 3'h1;
		pwm_tick <= (tick_cnt == 3'h7);
		if (rnd_en) begin
			volt_alpha <= $signed(xs_next());
			volt_beta <= $signed(xs_next());
			curr_alpha <= $signed(xs_next());
			curr_beta <= $signed(xs_next());
		end
	end

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_rng(input string what, input int lo, input int hi, input int g);
		n_checks++;
		if (g < lo || g > hi) begin
			n_mismatch++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, g);
		end
	endtask

	// Sampled two edges after the read is taken, so either read latency is safe
	always @(negedge mclk) begin
		if (rd_due) begin
			rd_due = 1'b0;
			chk(name_q.pop_front(), exp_q.pop_front(), prm_rdata);
		end
	end

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		prm_addr <= a;
		prm_wdata <= d;
		prm_wr <= 1'b1;
		@(posedge mclk);
		prm_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e, input string what);
		@(posedge mclk);
		prm_addr <= a;
		prm_rd <= 1'b1;
		@(posedge mclk);
		prm_rd <= 1'b0;
		exp_q.push_back(e);
		name_q.push_back(what);
		@(posedge mclk);
		rd_due = 1'b1;
	endtask

	function automatic logic cond(input int which);
		case (which)
			0: return parking_active === 1'b1;
			1: return open_loop_active === 1'b1;
			2: return closed_loop_active === 1'b1;
			3: return (start_ok | start_fail) === 1'b1;
			4: return parking_active === 1'b0;
			default: return (parking_active | open_loop_active | closed_loop_active) === 1'b0;
		endcase
	endfunction

	task automatic wait_for(input int which, input int bound, output int cyc, output int tk);
		cyc = 0;
		tk = 0;
		@(negedge mclk);
		while (!cond(which) && cyc < bound) begin
			if (pwm_tick === 1'b1 && open_loop_active === 1'b1) tk++;
			@(negedge mclk);
			cyc++;
		end
		if (cyc >= bound) begin
			n_mismatch++;
			$display("ERROR wait %0d expected done seen timeout", which);
			report_and_stop();
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		int cyc;
		int tk;
		logic [15:0] a1, a2, pc;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 17; i++) rd(addrs[i], 16'h0000, "reset value");
		rd(16'h8002, 16'h0000, "unmapped");
		// Zero estimator gains keep the flux at zero, so the band outcome is known
		motor_current <= 16'h0800;
		wr(sse_pkg::A_TORQUE, 16'h4000);
		wr(sse_pkg::A_SWITCH, 16'h0064);
		wr(sse_pkg::A_FLX_HIGH, 16'h0001);
		wr(sse_pkg::A_CHK_DLY, 16'h0003);
		wr(sse_pkg::A_FILT_BW, 16'h00ff);
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk);
			quad_frequency_scale_flag <= (k == 2);
			double_frequency_scale_flag <= (k == 1);
			quad_magnitude_scale_flag <= (k == 2);
			double_magnitude_scale_flag <= (k == 1);
			wr(sse_pkg::A_FLX_LOW, (k == 2) ? 16'h0001 : 16'h0000);
			repeat (20) @(posedge mclk);
			drive_run <= 1'b1;
			wait_for(2, 1000, cyc, tk);
			chk_rng("ticks to close", (100 * (1 << k) + 15) / 16 - 2, (100 * (1 << k) + 15) / 16 + 2, tk);
			wait_for(3, 200, cyc, tk);
			chk_rng("check delay", 3 * UNIT - 2, 3 * UNIT + 3, cyc);
			// Slow filter has moved off zero but stays well below the switch frequency
			chk_rng("filtered freq", 1, 99, int'(filtered_freq));
			chk("start_ok", {15'h0000, k != 2}, {15'h0000, start_ok});
			chk("start_fail", {15'h0000, k == 2}, {15'h0000, start_fail});
			rd(sse_pkg::A_STATUS, (k == 2) ? 16'h0038 : 16'h0058, "status");
			@(posedge mclk);
			drive_run <= 1'b0;
			wait_for(5, 10, cyc, tk);
		end
		for (int i = 0; i < 17; i++) begin
			vals[i] = xs_next();
			wr(addrs[i], vals[i]);
		end
		wr(16'h8000, 16'hffff);
		for (int i = 0; i < 17; i++) rd(addrs[i], vals[i], "readback");
		rd(16'h8000, 16'h0000, "unmapped write");
		rnd_en <= 1'b1;
		a1 = xs_next() & 16'h00ff;
		a2 = xs_next() & 16'h00ff;
		pc = xs_next() & 16'h00ff;
		wr(sse_pkg::A_PARK_ANG1, a1);
		wr(sse_pkg::A_PARK_ANG2, a2);
		wr(sse_pkg::A_PARK_CUR, pc);
		wr(sse_pkg::A_PARK_DUR, 16'h0002);
		repeat (20) @(posedge mclk);
		drive_run <= 1'b1;
		wait_for(0, 10, cyc, tk);
		chk("fail cleared", 16'h0000, {15'h0000, start_fail});
		repeat (2) @(negedge mclk);
		chk("first angle", {a1[7:0], 8'h00}, rotor_angle);
		chk("park current", pc, {8'h00, park_current_cmd});
		repeat (15) @(negedge mclk);
		chk("second angle", {a2[7:0], 8'h00}, rotor_angle);
		wait_for(4, 100, cyc, tk);
		chk_rng("park length", 2 * 4 * QTR - 3, 2 * 4 * QTR + 2, cyc + 17);
		@(posedge mclk);
		drive_run <= 1'b0;
		wait_for(5, 10, cyc, tk);
		chk("idle current", 16'h0000, {8'h00, park_current_cmd});
		diagnostic_selector <= sse_pkg::DIAG_PARK;
		wr(sse_pkg::A_PARK_DUR, 16'h0001);
		repeat (20) @(posedge mclk);
		drive_run <= 1'b1;
		wait_for(0, 10, cyc, tk);
		repeat (200) @(negedge mclk);
		chk("diag parking", 16'h0001, {15'h0000, parking_active});
		@(posedge mclk);
		drive_run <= 1'b0;
		wait_for(5, 10, cyc, tk);
		diagnostic_selector <= 4'h0;
		wr(sse_pkg::A_PARK_DUR, 16'h0000);
		repeat (20) @(posedge mclk);
		drive_run <= 1'b1;
		wait_for(1, 4, cyc, tk);
		chk("open after zero park", 16'h0001, {15'h0000, open_loop_active});
		@(posedge mclk);
		drive_run <= 1'b0;
		repeat (5) @(posedge mclk);
		report_and_stop();
	end
endmodule

/* verilog/sse_pkg.sv */
package sse_pkg;
	localparam int NPRM = 17;
	localparam int IDXW = 5;
	// Parameter index inside the storage arrays
	localparam int I_CURR_GAIN = 0;
	localparam int I_VOLT_GAIN = 1;
	localparam int I_TORQUE = 2;
	localparam int I_SALIENCY = 3;
	localparam int I_RESIST = 4;
	localparam int I_MEAN_IND = 5;
	localparam int I_PROP = 6;
	localparam int I_INTEG = 7;
	localparam int I_SWITCH = 8;
	localparam int I_PARK_DUR = 9;
	localparam int I_PARK_CUR = 10;
	localparam int I_PARK_ANG1 = 11;
	localparam int I_PARK_ANG2 = 12;
	localparam int I_FLX_LOW = 13;
	localparam int I_FLX_HIGH = 14;
	localparam int I_FILT_BW = 15;
	localparam int I_CHK_DLY = 16;
	// Parameter addresses in the controller's map
	localparam logic [15:0] A_CURR_GAIN = 16'h80b6;
	localparam logic [15:0] A_VOLT_GAIN = 16'h80cc;
	localparam logic [15:0] A_TORQUE = 16'h80d8;
	localparam logic [15:0] A_SALIENCY = 16'h80e4;
	localparam logic [15:0] A_RESIST = 16'h80e6;
	localparam logic [15:0] A_MEAN_IND = 16'h80e8;
	localparam logic [15:0] A_PROP = 16'h810c;
	localparam logic [15:0] A_INTEG = 16'h810e;
	localparam logic [15:0] A_SWITCH = 16'h8148;
	localparam logic [15:0] A_PARK_DUR = 16'h8188;
	localparam logic [15:0] A_PARK_CUR = 16'h8280;
	localparam logic [15:0] A_PARK_ANG1 = 16'h8284;
	localparam logic [15:0] A_PARK_ANG2 = 16'h8286;
	localparam logic [15:0] A_FLX_LOW = 16'h828c;
	localparam logic [15:0] A_FLX_HIGH = 16'h828e;
	localparam logic [15:0] A_FILT_BW = 16'h8386;
	localparam logic [15:0] A_CHK_DLY = 16'h83c2;
	localparam logic [15:0] A_STATUS = 16'h83f0;
	localparam logic [15:0] A_FREQ = 16'h83f2;
	localparam logic [15:0] PRM_RST = 16'h0000;
	// Fixed-point shifts
	localparam int GAIN_SHIFT = 15;
	localparam int PLL_SHIFT = 13;
	localparam int LPF_SHIFT = 13;
	localparam int OL_SHIFT = 21;
	localparam int ANG_SHIFT = 4;
	localparam int LEAK_SHIFT = 8;
	localparam int PARK_ANG_SHIFT = 8;
	localparam int THR_H_SHIFT = 7;
	localparam int THR_L_SHIFT = 6;
	localparam logic [3:0] DIAG_PARK = 4'h1;
	localparam logic signed [31:0] COMP_LIM = 32'sh0000_2000;
	localparam logic [15:0] TAU_GAIN = 16'h0400;
	// Timing
	localparam int MCLK_HZ = 40_000_000;
	localparam real PARK_UNIT_S = 0.01568627;
	localparam real CHK_UNIT_MS = 1.966;
	localparam int PARK_QTR_CYC = int'(PARK_UNIT_S * MCLK_HZ / 4.0);
	localparam int CHK_UNIT_CYC = int'(CHK_UNIT_MS * MCLK_HZ / 1000.0);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PARK = 4'b0010,
		ST_OPEN = 4'b0100,
		ST_CLOSED = 4'b1000
	} sse_state_t;
endpackage

/* verilog/sse_top.sv */
`timescale 1ns/10ps
// Functional notes
// - Low-pass filter estimated frequency, bandwidth/8192 per period
// - Compensate integrator lag by arctan(freq times tau)
// - Mean inductance gain used in flux estimate
// - Saliency inductance gain used in flux estimate
// - Integral gain turns tracking error into frequency
// - Proportional gain added to tracked frequency
// - Open-loop acceleration from torque gain times current
// - First angle for first quarter, then second
// - Parking current command from 8-bit parameter
// - Parking lasts duration times 15.686 ms
// - Parking diagnostic holds parking while running
// - Switch to closed loop at threshold frequency
// - Frequency scaler 4, 2 or 1 by flags
// - Flux band check raises start-fail indication
// - Upper threshold times 128, lower times 64
// - Magnitude scaler 4, 2 or 1 by flags
// - Flux sampled flux-check times 1.966 ms after closing
// - Separate voltage and current estimator gains
// - Phase resistance used in voltage drop
// - Every parameter is 16 bits, resets zero
module sse_top #(
	parameter int PARK_QTR_CYC = sse_pkg::PARK_QTR_CYC,
	parameter int CHK_UNIT_CYC = sse_pkg::CHK_UNIT_CYC,
	parameter logic [15:0] TAU_GAIN = sse_pkg::TAU_GAIN
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [15:0] prm_addr,
	input wire logic prm_wr,
	input wire logic [15:0] prm_wdata,
	input wire logic prm_rd,
	output logic [15:0] prm_rdata,
	input wire logic pwm_tick,
	input wire logic drive_run,
	input wire logic [3:0] diagnostic_selector,
	input wire logic quad_frequency_scale_flag,
	input wire logic double_frequency_scale_flag,
	input wire logic quad_magnitude_scale_flag,
	input wire logic double_magnitude_scale_flag,
	input wire logic signed [15:0] volt_alpha,
	input wire logic signed [15:0] volt_beta,
	input wire logic signed [15:0] curr_alpha,
	input wire logic signed [15:0] curr_beta,
	input wire logic [15:0] motor_current,
	output logic [15:0] rotor_angle,
	output logic [15:0] filtered_freq,
	output logic [7:0] park_current_cmd,
	output logic parking_active,
	output logic open_loop_active,
	output logic closed_loop_active,
	output logic start_fail,
	output logic start_ok
);
	typedef struct packed {
		sse_pkg::sse_state_t st;
		logic [sse_pkg::NPRM-1:0][15:0] shadow;
		logic [sse_pkg::NPRM-1:0][15:0] active;
		logic [15:0] rdata;
		logic [19:0] pre;
		logic [10:0] q;
		logic chk_done;
		logic fail;
		logic ok;
		logic signed [31:0] fla;
		logic signed [31:0] flb;
		logic signed [31:0] fint;
		logic signed [31:0] fest;
		logic signed [31:0] filt;
		logic [31:0] olacc;
		logic [15:0] ang;
		logic [15:0] ang_out;
		logic [7:0] cur_out;
	} sse_regs_t;

	sse_regs_t state_reg;
	sse_regs_t state_next;

	function automatic logic [5:0] prm_index(input logic [15:0] a);
		logic [5:0] r;
		r = 6'h20;
		if (a == sse_pkg::A_CURR_GAIN) r = 6'(sse_pkg::I_CURR_GAIN);
		else if (a == sse_pkg::A_VOLT_GAIN) r = 6'(sse_pkg::I_VOLT_GAIN);
		else if (a == sse_pkg::A_TORQUE) r = 6'(sse_pkg::I_TORQUE);
		else if (a == sse_pkg::A_SALIENCY) r = 6'(sse_pkg::I_SALIENCY);
		else if (a == sse_pkg::A_RESIST) r = 6'(sse_pkg::I_RESIST);
		else if (a == sse_pkg::A_MEAN_IND) r = 6'(sse_pkg::I_MEAN_IND);
		else if (a == sse_pkg::A_PROP) r = 6'(sse_pkg::I_PROP);
		else if (a == sse_pkg::A_INTEG) r = 6'(sse_pkg::I_INTEG);
		else if (a == sse_pkg::A_SWITCH) r = 6'(sse_pkg::I_SWITCH);
		else if (a == sse_pkg::A_PARK_DUR) r = 6'(sse_pkg::I_PARK_DUR);
		else if (a == sse_pkg::A_PARK_CUR) r = 6'(sse_pkg::I_PARK_CUR);
		else if (a == sse_pkg::A_PARK_ANG1) r = 6'(sse_pkg::I_PARK_ANG1);
		else if (a == sse_pkg::A_PARK_ANG2) r = 6'(sse_pkg::I_PARK_ANG2);
		else if (a == sse_pkg::A_FLX_LOW) r = 6'(sse_pkg::I_FLX_LOW);
		else if (a == sse_pkg::A_FLX_HIGH) r = 6'(sse_pkg::I_FLX_HIGH);
		else if (a == sse_pkg::A_FILT_BW) r = 6'(sse_pkg::I_FILT_BW);
		else if (a == sse_pkg::A_CHK_DLY) r = 6'(sse_pkg::I_CHK_DLY);
		prm_index = r;
	endfunction

	function automatic logic signed [31:0] mulsh(input logic [15:0] g,
		input logic signed [31:0] x, input int sh);
		logic signed [48:0] p;
		p = $signed({1'b0, g}) * 49'(x);
		mulsh = 32'(p >>> sh);
	endfunction

	// Piecewise-linear sine; cheap, and the loop only needs the sign and slope
	function automatic logic signed [15:0] tri_wave(input logic [15:0] a);
		logic [15:0] p;
		p = {1'b0, (a[14] ? ~a[13:0] : a[13:0]), 1'b0};
		tri_wave = a[15] ? -$signed(p) : $signed(p);
	endfunction

	function automatic logic signed [31:0] abs32(input logic signed [31:0] x);
		abs32 = x[31] ? -x : x;
	endfunction

	logic [5:0] widx;
	logic [5:0] ridx;
	logic [1:0] fsh;
	logic [1:0] msh;
	logic signed [31:0] ia;
	logic signed [31:0] ib;
	logic signed [31:0] fa;
	logic signed [31:0] fb;
	logic signed [31:0] err;
	logic signed [31:0] comp;
	logic signed [47:0] e48;
	logic [31:0] mag;
	logic [31:0] olf;
	logic [15:0] dur;
	logic park_first;
	logic park_done;
	logic chk_due;

	always_comb begin
		widx = prm_index(prm_addr);
		ridx = widx;
		state_next = state_reg;
		fsh = quad_frequency_scale_flag ? 2'h2 : (double_frequency_scale_flag ? 2'h1 : 2'h0);
		msh = quad_magnitude_scale_flag ? 2'h2 : (double_magnitude_scale_flag ? 2'h1 : 2'h0);
		dur = state_reg.active[sse_pkg::I_PARK_DUR];
		park_first = state_reg.q < 11'(dur[7:0]);
		park_done = state_reg.q >= {1'b0, dur[7:0], 2'b00};
		chk_due = state_reg.q >= 11'(state_reg.active[sse_pkg::I_CHK_DLY][7:0]);
		ia = mulsh(state_reg.active[sse_pkg::I_CURR_GAIN], 32'(curr_alpha), sse_pkg::GAIN_SHIFT);
		ib = mulsh(state_reg.active[sse_pkg::I_CURR_GAIN], 32'(curr_beta), sse_pkg::GAIN_SHIFT);
		// Stator flux minus inductive part; alpha and beta both use mean minus saliency
		fa = state_reg.fla - mulsh(state_reg.active[sse_pkg::I_MEAN_IND], ia, sse_pkg::GAIN_SHIFT)
			+ mulsh(state_reg.active[sse_pkg::I_SALIENCY], ia, sse_pkg::GAIN_SHIFT);
		fb = state_reg.flb - mulsh(state_reg.active[sse_pkg::I_MEAN_IND], ib, sse_pkg::GAIN_SHIFT)
			+ mulsh(state_reg.active[sse_pkg::I_SALIENCY], ib, sse_pkg::GAIN_SHIFT);
		mag = 32'((abs32(fa) + abs32(fb)) << msh);
		e48 = 48'(fb) * 48'(tri_wave(state_reg.ang + 16'h4000))
			- 48'(fa) * 48'(tri_wave(state_reg.ang));
		err = 32'(e48 >>> sse_pkg::GAIN_SHIFT);
		olf = state_reg.olacc >> (sse_pkg::OL_SHIFT + int'(fsh));
		// Small-angle arctan; saturates so a bad tau cannot flip the angle
		comp = mulsh(TAU_GAIN, state_reg.filt, sse_pkg::GAIN_SHIFT);
		if (comp > sse_pkg::COMP_LIM) begin
			comp = sse_pkg::COMP_LIM;
		end else if (comp < -sse_pkg::COMP_LIM) begin
			comp = -sse_pkg::COMP_LIM;
		end

		if (prm_wr && !widx[5]) begin
			state_next.shadow[widx[4:0]] = prm_wdata;
		end
		if (prm_rd) begin
			if (!ridx[5]) begin
				state_next.rdata = state_reg.shadow[ridx[4:0]];
			end else if (prm_addr == sse_pkg::A_STATUS) begin
				state_next.rdata = {9'h000, state_reg.ok, state_reg.fail, state_reg.chk_done,
					state_reg.st};
			end else if (prm_addr == sse_pkg::A_FREQ) begin
				state_next.rdata = state_reg.filt[15:0];
			end else begin
				state_next.rdata = 16'h0000;
			end
		end
		// Shadow copy only moves on the update strobe
		if (pwm_tick) begin
			state_next.active = state_reg.shadow;
		end

		state_next.pre = state_reg.pre + 20'h0_0001;
		case (state_reg.st)
			sse_pkg::ST_IDLE: begin
				state_next.pre = 20'h0_0000;
				state_next.q = 11'h000;
				if (drive_run) begin
					state_next.st = sse_pkg::ST_PARK;
					state_next.fail = 1'b0;
					state_next.ok = 1'b0;
					state_next.chk_done = 1'b0;
					state_next.fla = 32'sh0000_0000;
					state_next.flb = 32'sh0000_0000;
					state_next.fint = 32'sh0000_0000;
					state_next.fest = 32'sh0000_0000;
					state_next.filt = 32'sh0000_0000;
					state_next.olacc = 32'h0000_0000;
				end
			end
			sse_pkg::ST_PARK: begin
				if (state_reg.pre == 20'(PARK_QTR_CYC - 1)) begin
					state_next.pre = 20'h0_0000;
					if (state_reg.q != 11'h7ff) begin
						state_next.q = state_reg.q + 11'h001;
					end
				end
				state_next.ang = park_first ?
					16'(state_reg.active[sse_pkg::I_PARK_ANG1][7:0]) << sse_pkg::PARK_ANG_SHIFT :
					16'(state_reg.active[sse_pkg::I_PARK_ANG2][7:0]) << sse_pkg::PARK_ANG_SHIFT;
				if (diagnostic_selector != sse_pkg::DIAG_PARK && park_done) begin
					state_next.st = sse_pkg::ST_OPEN;
				end
			end
			sse_pkg::ST_OPEN: begin
				if (pwm_tick) begin
					state_next.olacc = state_reg.olacc
						+ 32'(state_reg.active[sse_pkg::I_TORQUE]) * 32'(motor_current);
					state_next.ang = state_reg.ang + 16'((olf << fsh) >> sse_pkg::ANG_SHIFT);
					if (olf >= 32'(state_reg.active[sse_pkg::I_SWITCH])) begin
						state_next.st = sse_pkg::ST_CLOSED;
						state_next.fint = $signed(olf);
						state_next.fest = $signed(olf);
						state_next.pre = 20'h0_0000;
						state_next.q = 11'h000;
					end
				end
			end
			sse_pkg::ST_CLOSED: begin
				if (state_reg.pre == 20'(CHK_UNIT_CYC - 1)) begin
					state_next.pre = 20'h0_0000;
					if (state_reg.q != 11'h7ff) begin
						state_next.q = state_reg.q + 11'h001;
					end
				end
				if (!state_reg.chk_done && chk_due) begin
					state_next.chk_done = 1'b1;
					// Inside the band counts as a good start
					if (mag <= 32'(state_reg.active[sse_pkg::I_FLX_HIGH][7:0]) << sse_pkg::THR_H_SHIFT
						&& mag >= 32'(state_reg.active[sse_pkg::I_FLX_LOW][7:0]) << sse_pkg::THR_L_SHIFT) begin
						state_next.ok = 1'b1;
					end else begin
						state_next.fail = 1'b1;
					end
				end
				if (pwm_tick) begin
					state_next.fint = state_reg.fint
						+ mulsh(state_reg.active[sse_pkg::I_INTEG], err, sse_pkg::PLL_SHIFT);
					state_next.fest = state_next.fint
						+ mulsh(state_reg.active[sse_pkg::I_PROP], err, sse_pkg::PLL_SHIFT);
					state_next.ang = state_reg.ang
						+ 16'((state_reg.fest <<< fsh) >>> sse_pkg::ANG_SHIFT);
				end
			end
			default: begin
				state_next.st = sse_pkg::ST_IDLE;
			end
		endcase

		if (pwm_tick && state_reg.st != sse_pkg::ST_IDLE) begin
			// Leaky integrator instead of a pure one, so offsets cannot wind up
			state_next.fla = state_reg.fla - (state_reg.fla >>> sse_pkg::LEAK_SHIFT)
				+ mulsh(state_reg.active[sse_pkg::I_VOLT_GAIN], 32'(volt_alpha), sse_pkg::GAIN_SHIFT)
				- mulsh(state_reg.active[sse_pkg::I_RESIST], ia, sse_pkg::GAIN_SHIFT);
			state_next.flb = state_reg.flb - (state_reg.flb >>> sse_pkg::LEAK_SHIFT)
				+ mulsh(state_reg.active[sse_pkg::I_VOLT_GAIN], 32'(volt_beta), sse_pkg::GAIN_SHIFT)
				- mulsh(state_reg.active[sse_pkg::I_RESIST], ib, sse_pkg::GAIN_SHIFT);
			state_next.filt = state_reg.filt + mulsh(state_reg.active[sse_pkg::I_FILT_BW],
				state_reg.fest - state_reg.filt, sse_pkg::LPF_SHIFT);
		end
		if (!drive_run) begin
			state_next.st = sse_pkg::ST_IDLE;
		end
		state_next.cur_out = (state_reg.st == sse_pkg::ST_PARK) ?
			state_reg.active[sse_pkg::I_PARK_CUR][7:0] : 8'h00;
		state_next.ang_out = (state_reg.st == sse_pkg::ST_CLOSED) ?
			state_reg.ang + comp[15:0] : state_reg.ang;
		if (state_reg.st == sse_pkg::ST_PARK) begin
			state_next.ang_out = state_next.ang;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= '0;
			state_reg.st <= sse_pkg::ST_IDLE;
			state_reg.shadow <= {sse_pkg::NPRM{sse_pkg::PRM_RST}};
			state_reg.active <= {sse_pkg::NPRM{sse_pkg::PRM_RST}};
		end else begin
			state_reg <= state_next;
		end
	end

	assign prm_rdata = state_reg.rdata;
	assign rotor_angle = state_reg.ang_out;
	assign filtered_freq = state_reg.filt[15:0];
	assign park_current_cmd = state_reg.cur_out;
	assign parking_active = state_reg.st == sse_pkg::ST_PARK;
	assign open_loop_active = state_reg.st == sse_pkg::ST_OPEN;
	assign closed_loop_active = state_reg.st == sse_pkg::ST_CLOSED;
	assign start_fail = state_reg.fail;
	assign start_ok = state_reg.ok;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_RST_ZERO: assert property (disable iff (1'b0) reset |=> state_reg.active == '0)
		else $error("parameters not zero after reset");
	AST_HOLD: assert property (!pwm_tick |=> $stable(state_reg.active))
		else $error("parameters changed between updates");
	// A start from idle clears the filter off the update strobe, so idle is left out
	AST_FILT_HOLD: assert property (!pwm_tick && drive_run && state_reg.st != sse_pkg::ST_IDLE
		|=> $stable(state_reg.filt))
		else $error("frequency filter moved off update");
	AST_PARK_FIRST: assert property (parking_active && park_first && drive_run
		|=> rotor_angle == {$past(state_reg.active[sse_pkg::I_PARK_ANG1][7:0]), 8'h00})
		else $error("first parking angle not applied");
	AST_PARK_CUR: assert property (parking_active
		|=> park_current_cmd == $past(state_reg.active[sse_pkg::I_PARK_CUR][7:0]))
		else $error("parking current mismatch");
	AST_PARK_END: assert property (parking_active && park_done && drive_run
		&& diagnostic_selector != sse_pkg::DIAG_PARK |=> open_loop_active)
		else $error("parking did not end on time");
	AST_DIAG: assert property (parking_active && drive_run
		&& diagnostic_selector == sse_pkg::DIAG_PARK |=> parking_active)
		else $error("diagnostic parking left early");
	AST_SWITCH: assert property (open_loop_active && pwm_tick && drive_run
		&& olf >= 32'(state_reg.active[sse_pkg::I_SWITCH]) |=> closed_loop_active)
		else $error("no switch to closed loop");
	AST_FSCL: assert property (quad_frequency_scale_flag |-> fsh == 2'h2)
		else $error("frequency scaler not four");
	AST_MSCL: assert property (!quad_magnitude_scale_flag && double_magnitude_scale_flag
		|-> msh == 2'h1)
		else $error("magnitude scaler not two");
	AST_FAIL: assert property (closed_loop_active && drive_run && !state_reg.chk_done && chk_due
		&& mag > 32'(state_reg.active[sse_pkg::I_FLX_HIGH][7:0]) << sse_pkg::THR_H_SHIFT
		|=> start_fail && !start_ok)
		else $error("start fail not raised");
	AST_FAIL_SRC: assert property ($rose(start_fail) |-> $past(closed_loop_active && chk_due))
		else $error("start fail outside flux check");
	AST_OL_ACC: assert property (open_loop_active && !pwm_tick |=> $stable(state_reg.olacc))
		else $error("open-loop ramp moved off update");

	COV_PARK: cover property (parking_active ##1 open_loop_active);
	COV_CLOSE: cover property (open_loop_active ##1 closed_loop_active);
	COV_FAIL: cover property ($rose(start_fail));
	COV_OK: cover property ($rose(start_ok));
endmodule
